// File: verilog/cxpi_node_mode_codec.sv
/*
 Mode control and UART-to-bus codec of a clock-embedding single-wire node.
 Assumes all pins are asynchronous to ref_clk and open-drain style:
 an enable high pulls the pin low, the out ports hold a constant low.
*/
`timescale 1ns/1ns
// Functional notes
// R1: Role pin low: master, clock pin is input.
// R2: Role pin high: slave, recovered clock driven out.
// R3: Master puts the baud clock onto bus.
// R4: Controller keeps role steady in Normal, wake.
// R5: Normal mode encodes tx stream, decodes bus.
// R6: Controller sends UART characters, LSB first.
// R7: Decoded bytes leave as UART characters.
// R8: Power-up lands in Sleep.
// R9: Bus error or sleep request returns Sleep.
// R10: Wake condition moves Sleep to Standby.
// R11: Master Sleep passes raw bus to rx.
// R12: Sleep starts on sleep pin falling.
// R13: Sleep pin low kills bus driver.
// R14: Bus, rx high impedance after release.
// R15: Master stops clock high, waits, then sleeps.
// R16: Standby only from Sleep, silent, then Normal.
// R17: Master bus waits for 33 clock periods.
// R18: Wake events last at least mode change time.
// R19: Sleep pin low means sleep, high allows.
// R20: Clock frequency equals bus bit rate.
// R21: Bits use pulse-width coding on bus.
module cxpi_node_mode_codec #(
   parameter int BUS_ERR_CYC = cxpi_node_pkg::BUS_ERR_CYC
) (
   // Clock, reset, enable
   input  wire logic ref_clk,
   input  wire logic rst_n,
   input  wire logic ce,
   // Controller control pins
   input  wire logic roleSelect,
   input  wire logic sleepControlN,
   // Controller data pins
   input  wire logic txDataIn,
   output logic      rxDataOut,
   output logic      rxDataOe,
   // Baud clock pin
   input  wire logic clkPinIn,
   output logic      clkPinOut,
   output logic      clkPinOe,
   // Bus pin
   input  wire logic busIn,
   output logic      busOut,
   output logic      busOe
);

   localparam int PW = cxpi_node_pkg::PER_W;

   cxpi_node_pkg::mode_type modeQ;
   cxpi_node_pkg::mode_type modeD;

   logic [cxpi_node_pkg::SYNC_W-1:0]    pinS;
   logic                                roleQ;
   logic                                clkPrev_q;
   logic                                busPrev_q;
   logic [PW-1:0]                       perCnt_q;
   logic [PW-1:0]                       period_q;
   logic [PW-1:0]                       lowLen_q;
   logic [PW-1:0]                       errCnt_q;
   logic [PW-1:0]                       sinceFall_q;
   logic [cxpi_node_pkg::CHG_W-1:0]     chgCnt_q;
   logic [cxpi_node_pkg::EDGE_W-1:0]    edgeCnt_q;
   logic                                decValid_q;
   logic                                decBit_q;
   logic                                rxBit_q;
   logic [PW-1:0]                       rxCnt_q;
   logic                                bufInReady;
   logic                                bufOutValid;
   logic                                bufOutData;

   // Low time of one coded bit: short for one, long for zero
   function automatic logic [PW-1:0] lowTime(input logic b,
                                             input logic [PW-1:0] p);
      lowTime = b ? (p >> 2) : (p >> 1);
   endfunction

   // Decision point between the two low times
   function automatic logic [PW-1:0] sampPt(input logic [PW-1:0] p);
      sampPt = PW'((p >> 2) + (p >> 3));
   endfunction

   // All pins pass two flops before use
   cxpi_sync #(
      .W (cxpi_node_pkg::SYNC_W)
   ) u_sync (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .ce      (ce),
      .d       ({roleSelect, sleepControlN, txDataIn, clkPinIn, busIn}),
      .q       (pinS)
   );

   wire roleS = pinS[cxpi_node_pkg::IN_ROLE];
   wire nslpS = pinS[cxpi_node_pkg::IN_SLEEP_CONTROL_N];
   wire txS   = pinS[cxpi_node_pkg::IN_TXD];
   wire clkS  = pinS[cxpi_node_pkg::IN_CLK];
   wire busS  = pinS[cxpi_node_pkg::IN_BUS];

   // Edge finding and bit framing
   wire clkFall  = clkPrev_q && !clkS;
   wire clkRise  = !clkPrev_q && clkS;
   wire busFall  = busPrev_q && !busS;
   wire bitStart = roleQ ? busFall : clkFall; // R1 R2
   wire inNormal = (modeQ == cxpi_node_pkg::NORMAL);
   wire inSleep  = (modeQ == cxpi_node_pkg::SLEEP);
   wire busEn    = roleQ || (edgeCnt_q == cxpi_node_pkg::MASTER_EDGES);
   wire drvOk    = inNormal && busEn && nslpS; // R13 R17
   wire wantLow  = !roleQ || !txS; // R3 R5
   wire busErr   = (errCnt_q == PW'(BUS_ERR_CYC - 1));
   wire chgDone  = (chgCnt_q == cxpi_node_pkg::MODE_CHG_LAST);
   wire sampHit  = inNormal && (sinceFall_q == sampPt(period_q));
   wire rxPop    = bufOutValid && (rxCnt_q == '0);

   // Next driver and pin enables
   // Enable already stands in the bit-start cycle, so stop one count early
   wire busOeD = drvOk && (bitStart ? wantLow
                 : (busOe && (PW'(perCnt_q + 1'b1) < lowLen_q))); // R21
   wire rxOeD  = inSleep ? (!roleQ && !busS) // R11
               : (inNormal && nslpS && !rxBit_q); // R7 R14
   wire clkOeD = roleQ && (inSleep ? !busS
               : (inNormal && (perCnt_q < (period_q >> 1)))); // R2

   // Mode sequencing
   always_comb begin
      modeD = modeQ;
      case (modeQ)
         cxpi_node_pkg::SLEEP: begin
            if (nslpS) modeD = cxpi_node_pkg::STANDBY; // R10 R19
         end
         cxpi_node_pkg::STANDBY: begin
            if (!nslpS || busErr) modeD = cxpi_node_pkg::SLEEP; // R9
            else if (chgDone) modeD = cxpi_node_pkg::NORMAL; // R16 R14
         end
         cxpi_node_pkg::NORMAL: begin
            if (!nslpS || busErr) modeD = cxpi_node_pkg::SLEEP; // R9 R12
         end
         default: modeD = cxpi_node_pkg::SLEEP;
      endcase
   end

   // Mode state; power-up always lands in Sleep
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) modeQ <= cxpi_node_pkg::SLEEP; // R8
      else if (ce) modeQ <= modeD;
   end

   // Role is only taken while asleep so a pin glitch cannot flip it
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) roleQ <= 1'b0;
      else if (ce && inSleep) roleQ <= roleS; // R4
   end

   // Edge history
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         clkPrev_q <= 1'b0;
         busPrev_q <= 1'b0;
      end else if (ce) begin
         clkPrev_q <= clkS;
         busPrev_q <= busS;
      end
   end

   // Bit period follows link clock falls as master, bus falls as slave, one bit per period
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         perCnt_q <= cxpi_node_pkg::PER_RST;
         period_q <= cxpi_node_pkg::PER_MAX;
      end else if (ce) begin
         if (bitStart) begin
            period_q <= PW'(perCnt_q + 1'b1); // R20
            perCnt_q <= cxpi_node_pkg::PER_RST;
         end else if (perCnt_q != cxpi_node_pkg::PER_MAX) begin
            perCnt_q <= PW'(perCnt_q + 1'b1);
         end
      end
   end

   // Time since the synced bus fell; sync delay and drive lag drop out
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) sinceFall_q <= cxpi_node_pkg::PER_MAX;
      else if (ce) begin
         if (busFall) sinceFall_q <= 16'h0001;
         else if (sinceFall_q != cxpi_node_pkg::PER_MAX)
            sinceFall_q <= PW'(sinceFall_q + 1'b1);
      end
   end

   // Low length of the current bit, fixed at its start
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) lowLen_q <= cxpi_node_pkg::PER_RST;
      else if (ce && bitStart) lowLen_q <= lowTime(txS, period_q); // R21
   end

   // Master waits for link clock periods before driving
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) edgeCnt_q <= '0;
      else if (ce) begin
         if (!inNormal) edgeCnt_q <= '0;
         else if (clkRise && !busEn) edgeCnt_q <= edgeCnt_q + 1'b1; // R17
      end
   end

   // Quiet interval in Standby
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) chgCnt_q <= '0;
      else if (ce) begin
         if (modeQ != cxpi_node_pkg::STANDBY) chgCnt_q <= '0;
         else if (!chgDone) chgCnt_q <= chgCnt_q + 1'b1; // R16
      end
   end

   // Stuck-low bus watch, counts only outside Sleep
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) errCnt_q <= cxpi_node_pkg::PER_RST;
      else if (ce) begin
         if (busS || inSleep) errCnt_q <= cxpi_node_pkg::PER_RST;
         else if (!busErr) errCnt_q <= PW'(errCnt_q + 1'b1); // R9
      end
   end

   // Decoder holds its bit until the buffer takes it
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         decValid_q <= 1'b0;
         decBit_q   <= 1'b1;
      end else if (ce) begin
         if (sampHit) begin
            decValid_q <= 1'b1;
            decBit_q   <= busS; // R5 R21
         end else if (bufInReady) begin
            decValid_q <= 1'b0;
         end
      end
   end

   // Absorbs phase slip between bus bits and the rx bit slots
   cxpi_buf2 #(
      .W (cxpi_node_pkg::BUF_W),
      .D (cxpi_node_pkg::BUF_D)
   ) u_buf (
      .ref_clk  (ref_clk),
      .rst_n    (rst_n),
      .ce       (ce),
      .inValid  (decValid_q),
      .inReady  (bufInReady),
      .inData   (decBit_q),
      .outValid (bufOutValid),
      .outReady (rxPop),
      .outData  (bufOutData)
   );

   // Rx slot: each bit stands one period, keeping UART framing
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rxBit_q <= 1'b1;
         rxCnt_q <= cxpi_node_pkg::PER_RST;
      end else if (ce) begin
         if (!inNormal) begin
            rxBit_q <= 1'b1;
            rxCnt_q <= cxpi_node_pkg::PER_RST;
         end else if (rxPop) begin
            rxBit_q <= bufOutData; // R7
            rxCnt_q <= PW'(period_q - 1'b1);
         end else if (rxCnt_q != '0) begin
            rxCnt_q <= PW'(rxCnt_q - 1'b1);
         end
      end
   end

   // Pin drivers; pulled-up lines only ever pulled low
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         busOe     <= 1'b0;
         rxDataOe  <= 1'b0;
         clkPinOe  <= 1'b0;
         busOut    <= 1'b0;
         rxDataOut <= 1'b0;
         clkPinOut <= 1'b0;
      end else if (ce) begin
         busOe    <= busOeD; // R13
         rxDataOe <= rxOeD;
         clkPinOe <= clkOeD; // R1
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   sequence s_wake;
      inSleep && nslpS && ce;
   endsequence

   sequence s_quiet;
      (modeQ == cxpi_node_pkg::STANDBY) && ce && nslpS && !busErr
         && !chgDone;
   endsequence

   a_wake_standby: assert property ( // R10
      s_wake |=> modeQ == cxpi_node_pkg::STANDBY)
      else $error("wake did not enter standby");

   a_no_skip_standby: assert property ( // R16
      $rose(inNormal) |-> $past(modeQ) == cxpi_node_pkg::STANDBY
         && $past(chgCnt_q) == cxpi_node_pkg::MODE_CHG_LAST)
      else $error("normal entered without full standby");

   a_sleep_request: assert property ( // R12
      !nslpS && ce && !inSleep |=> inSleep)
      else $error("sleep request not honoured");

   a_driver_off: assert property ( // R13
      !nslpS && ce |=> !busOe)
      else $error("bus driven while sleep requested");

   a_quiet_pins: assert property ( // R14
      s_quiet |=> !busOe && !rxDataOe ##0
         modeQ == cxpi_node_pkg::STANDBY)
      else $error("pins not quiet in standby");

   a_master_gate: assert property ( // R17
      busOe && !roleQ |-> edgeCnt_q == cxpi_node_pkg::MASTER_EDGES)
      else $error("master drove bus before clock count");

   a_master_clk_in: assert property ( // R1
      !roleQ |-> !clkPinOe)
      else $error("master drove the clock pin");

   a_sleep_pass: assert property ( // R11
      inSleep && !roleQ && ce ##1 inSleep && ce
         |=> rxDataOe == !$past(busS))
      else $error("sleep rx does not follow bus");

   a_error_sleep: assert property ( // R9
      busErr && ce && !inSleep |=> inSleep)
      else $error("bus error did not force sleep");

endmodule // cxpi_node_mode_codec

// File: verilog/cxpi_node_pkg.sv
/*
 Shared constants and types of the single-wire node mode codec.
 Assumes a 10 MHz core clock; all times become cycles of that clock.
*/
package cxpi_node_pkg;

   // Core clock rate
   localparam int CLK_MHZ = 10;

   // Quiet time after a sleep release, in microseconds
   localparam int MODE_CHG_US = 100;
   localparam int MODE_CHG_CYC = MODE_CHG_US * CLK_MHZ;
   localparam int CHG_W = 10;
   localparam logic [CHG_W-1:0] MODE_CHG_LAST =
      CHG_W'(MODE_CHG_CYC - 1);

   // Bus held low this long counts as a bus error
   localparam int BUS_ERR_US = 2000;
   localparam int BUS_ERR_CYC = BUS_ERR_US * CLK_MHZ;

   // Link clock periods to see before the master drives the bus
   localparam int EDGE_W = 6;
   localparam logic [EDGE_W-1:0] MASTER_EDGES = 6'h21;

   // Bit timing counters
   localparam int PER_W = 16;
   localparam logic [PER_W-1:0] PER_MAX = 16'hFFFF;
   localparam logic [PER_W-1:0] PER_RST = 16'h0000;

   // Synchronised input vector: role, sleep, tx data, link clock, bus
   localparam int SYNC_W = 5;
   localparam int IN_ROLE = 4;
   localparam int IN_SLEEP_CONTROL_N = 3;
   localparam int IN_TXD = 2;
   localparam int IN_CLK = 1;
   localparam int IN_BUS = 0;

   // Receive buffer shape
   localparam int BUF_W = 1;
   localparam int BUF_D = 2;

   // Operating modes
   typedef enum logic [1:0] {
      SLEEP,
      STANDBY,
      NORMAL
   } mode_type;

endpackage

// File: verilog/cxpi_sync.sv
/*
 Two-flop synchroniser for a vector of pin levels.
 Assumes each bit is an independent level; no word coherence is given.
*/
`timescale 1ns/1ns
module cxpi_sync #(
   parameter int W = 1
) (
   // Clock, reset, enable
   input  wire logic         ref_clk,
   input  wire logic         rst_n,
   input  wire logic         ce,
   // Levels
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   logic [W-1:0] meta_q;

   // First stage feeds only the second stage
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= '0;
         q      <= '0;
      end else if (ce) begin
         meta_q <= d;
         q      <= meta_q;
      end
   end

endmodule // cxpi_sync

// File: verilog/cxpi_buf2.sv
/*
 Small valid/ready buffer; width and depth shape its storage.
 Assumes the filler holds data steady while valid is high and not ready.
*/
`timescale 1ns/1ns
module cxpi_buf2 #(
   parameter int W = 1,
   parameter int D = 2
) (
   // Clock, reset, enable
   input  wire logic         ref_clk,
   input  wire logic         rst_n,
   input  wire logic         ce,
   // Fill side
   input  wire logic         inValid,
   output logic              inReady,
   input  wire logic [W-1:0] inData,
   // Drain side
   output logic              outValid,
   input  wire logic         outReady,
   output logic      [W-1:0] outData
);

   localparam int PW = (D > 1) ? $clog2(D) : 1;

   logic [W-1:0]  mem_q [D];
   logic [PW-1:0] wrPtr_q;
   logic [PW-1:0] rdPtr_q;
   logic [PW:0]   count_q;
   wire           push = inValid && inReady;
   wire           pop  = outValid && outReady;

   // Honest flags straight from the fill count
   assign inReady  = (count_q != (PW+1)'(D));
   assign outValid = (count_q != '0);
   assign outData  = mem_q[rdPtr_q];

   function automatic logic [PW-1:0] nextPtr(input logic [PW-1:0] p);
      nextPtr = (p == PW'(D - 1)) ? '0 : PW'(p + 1'b1);
   endfunction

   // Pointers and count
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         wrPtr_q <= '0;
         rdPtr_q <= '0;
         count_q <= '0;
      end else if (ce) begin
         if (push) wrPtr_q <= nextPtr(wrPtr_q);
         if (pop) rdPtr_q <= nextPtr(rdPtr_q);
         count_q <= count_q + (PW+1)'(push) - (PW+1)'(pop);
      end
   end

   // Storage, no reset needed
   always_ff @(posedge ref_clk) begin
      if (ce && push) begin
         mem_q[wrPtr_q] <= inData;
      end
   end

endmodule // cxpi_buf2

// File: test/cxpi_ctrl_model.sv
/*
 Controller and far-node model: link clock, UART tx stream, bus pulls.
 Assumes the bench resolves the open-drain wires with pull-ups.
*/
`timescale 1ns/1ns
module cxpi_ctrl_model (
   // Clocks and control
   input  wire logic ref_clk,
   input  wire logic clkLine,
   input  wire logic clkRun,
   // Pulled or driven levels
   output logic      clkPull,
   output logic      busPull,
   output logic      txd
);
   // Link clock, 800 ns, stands high while stopped
   initial begin
      clkPull = 1'b0;
      busPull = 1'b0;
      txd = 1'b1;
      #20;
      forever begin
         #400;
         clkPull = clkRun & ~clkPull;
      end
   end

   // Changed on clock rise, so each bit start sees a settled level
   task automatic sendUart(input logic [7:0] b);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         @(posedge clkLine);
         txd = f[i];
      end
      @(posedge clkLine);
   endtask

   // Far master bits: short pull is 1, long pull is 0
   task automatic remoteBits(input logic [9:0] f);
      for (int i = 0; i < 10; i++) begin
         @(negedge ref_clk);
         busPull = 1'b1;
         repeat (f[i] ? 2 : 4) @(negedge ref_clk);
         busPull = 1'b0;
         repeat (f[i] ? 5 : 3) @(negedge ref_clk);
      end
   endtask

   // Plain low hold, for wake pulses and bus errors
   task automatic pullBus(input int n);
      @(negedge ref_clk);
      busPull = 1'b1;
      repeat (n) @(negedge ref_clk);
      busPull = 1'b0;
   endtask
endmodule // cxpi_ctrl_model

// File: test/tb_top.sv
/*
 Self-checking bench of the node mode codec, master then slave role.
 Assumes pull-ups on every open-drain pin and a 10 MHz core clock.
*/
`timescale 1ns/1ns
module tb_top;
   localparam int ERR_CYC = 200; // Short bus-error count
   logic       ref_clk, rst_n, ce, roleSelect, sleepControlN, clkRun;
   logic       rxDataOut, rxDataOe, clkPinOut, clkPinOe, busOut, busOe;
   logic       clkPull, busPull, txd;
   logic [7:0] val, got;
   logic [7:0] runLen = 8'h00;
   logic [7:0] lens[$];
   int         errors, checksDone, seed, edges, n, cb, cc, cr;
   // Open-drain wires with pull-ups
   wire logic  clkLine = ~(clkPull | clkPinOe);
   wire logic  busLine = ~(busOe | busPull);
   wire logic  rxLine = ~rxDataOe;

   initial ref_clk = 1'b0;
   always #50 ref_clk = ~ref_clk;

   cxpi_node_mode_codec #(.BUS_ERR_CYC(ERR_CYC)) u_dut (
      .ref_clk(ref_clk), .rst_n(rst_n), .ce(ce),
      .roleSelect(roleSelect), .sleepControlN(sleepControlN),
      .txDataIn(txd), .rxDataOut(rxDataOut), .rxDataOe(rxDataOe),
      .clkPinIn(clkLine), .clkPinOut(clkPinOut), .clkPinOe(clkPinOe),
      .busIn(busLine), .busOut(busOut), .busOe(busOe));
   cxpi_ctrl_model u_ctrl (
      .ref_clk(ref_clk), .clkLine(clkLine), .clkRun(clkRun),
      .clkPull(clkPull), .busPull(busPull), .txd(txd));

   // Widths of the node's bus pulls, and link clock rises
   always @(posedge ref_clk) begin
      if (busOe === 1'b1) begin
         runLen <= runLen + 8'h01;
      end else if (runLen != 8'h00) begin
         lens.push_back(runLen);
         runLen <= 8'h00;
      end
   end
   always @(posedge clkLine) edges++;

   task automatic cyc(input int k);
      repeat (k) @(negedge ref_clk);
   endtask

   task automatic check(input string what, input logic [31:0] exp,
                        input logic [31:0] seen);
      checksDone++;
      if (seen !== exp) begin
         errors++;
         $display("BAD %s expected %0h seen %0h", what, exp, seen);
      end
   endtask

   task automatic summarize();
      $display("Checks %0d, mismatches %0d", checksDone, errors);
      if (errors == 0 && checksDone > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   // Counts high cycles of bus, clock and rx pulls in a window
   task automatic countOe(input int len, output int nb, output int nc,
                          output int nr);
      nb = 0;
      nc = 0;
      nr = 0;
      repeat (len) begin
         @(negedge ref_clk);
         nb += (busOe === 1'b1);
         nc += (clkPinOe === 1'b1);
         nr += (rxDataOe === 1'b1);
      end
   endtask

   // UART receiver on rx, 8 cycles a bit, sampled mid-bit
   task automatic rxUart(output logic [7:0] b);
      int w;
      w = 0;
      while (rxLine !== 1'b0 && w < 2000) begin
         cyc(1);
         w++;
      end
      if (w >= 2000) begin
         check("rx start bit", 0, 1);
         summarize();
      end
      cyc(4);
      for (int i = 0; i < 8; i++) begin
         cyc(8);
         b[i] = rxLine;
      end
      cyc(8);
      check("rx stop bit", 1, rxLine);
   endtask

   // Byte from pulse widths: 4 cycles is 0, 2 cycles is 1
   function automatic logic [8:0] decodeTx();
      int s;
      logic [8:0] r;
      s = 0;
      r = 9'h000;
      while (s < lens.size() && lens[s] != 8'h04) s++;
      r[8] = (s + 8 < lens.size());
      for (int j = 0; j < 8; j++) r[j] = (lens[s + 1 + j] === 8'h02);
      return r;
   endfunction

   // Hang guard
   initial begin
      repeat (30000) @(posedge ref_clk);
      check("run time", 0, 1);
      summarize();
   end

   initial begin
      seed = 32'he0cb;
      errors = 0;
      checksDone = 0;
      rst_n = 1'b0;
      ce = 1'b1;
      roleSelect = 1'b0;
      sleepControlN = 1'b0;
      clkRun = 1'b0;
      edges = 0;
      cyc(10);
      rst_n = 1'b1;
      cyc(5);
      check("busOe after reset", 0, busOe);
      check("clkPinOe after reset", 0, clkPinOe);
      ce = 1'b0;
      fork u_ctrl.pullBus(50); join_none
      cyc(10);
      check("rx frozen by enable", 0, rxDataOe);
      ce = 1'b1;
      cyc(10);
      check("master raw rx low", 1, rxDataOe);
      cyc(40);
      check("master raw rx high", 0, rxDataOe);
      $display("master sleep test done");
      sleepControlN = 1'b1;
      cyc(20);
      fork u_ctrl.pullBus(100); join_none
      countOe(880, cb, cc, cr);
      check("standby bus quiet", 0, cb);
      check("standby rx quiet", 0, cr);
      cyc(200);
      edges = 0;
      clkRun = 1'b1;
      n = 0;
      while (busOe !== 1'b1 && n < 1000) begin
         cyc(1);
         n++;
      end
      check("clock rises before drive", 33, edges);
      if (n >= 1000) summarize();
      for (int k = 0; k < 3; k++) begin
         val = (k == 0) ? 8'h00 : (k == 1) ? 8'hFF : 8'($random(seed));
         lens.delete();
         fork
            u_ctrl.sendUart(val);
            rxUart(got);
         join
         check("master rx byte", val, got);
         check("master tx byte", {1'b1, val}, decodeTx());
      end
      $display("master normal test done");
      clkRun = 1'b0;
      cyc(20);
      u_ctrl.pullBus(300);
      clkRun = 1'b1;
      countOe(500, cb, cc, cr);
      check("silent after bus error", 0, cb);
      cyc(1000);
      countOe(100, cb, cc, cr);
      check("driving again", 1, cb > 0);
      check("master clock pin input", 0, cc);
      sleepControlN = 1'b0;
      cyc(4);
      countOe(100, cb, cc, cr);
      check("driver off in sleep", 0, cb);
      check("pin low levels", 0, {busOut, clkPinOut, rxDataOut});
      $display("bus error and sleep test done");
      clkRun = 1'b0;
      roleSelect = 1'b1;
      cyc(20);
      fork u_ctrl.pullBus(50); join_none
      cyc(10);
      check("slave raw bus on clock", 1, clkPinOe);
      check("slave rx released", 0, rxDataOe);
      cyc(60);
      sleepControlN = 1'b1;
      cyc(1100);
      val = 8'($random(seed));
      fork
         begin
            repeat (4) u_ctrl.remoteBits(10'h3FF);
            u_ctrl.remoteBits({1'b1, val, 1'b0});
            repeat (3) u_ctrl.remoteBits(10'h3FF);
         end
         begin
            rxUart(got);
            countOe(80, cb, cc, cr);
         end
      join
      check("slave rx byte", val, got);
      check("slave clock half periods", 40, cc);
      check("slave idle tx quiet", 0, cb);
      $display("slave test done");
      summarize();
   end
endmodule // tb_top
